// ==== include/cir_pkg.sv ====
// Constants for the card information register bank: field layouts,
// fixed record values, reset values and block timing.
// Assumes a single 50 MHz core clock.
package cir_pkg;

    // Core clock period and block-to-block gap times.
    localparam int CLK_PERIOD_NS = 20;
    localparam int GAP_SHORT_NS  = 1000;
    localparam int GAP_LONG_NS   = 62000;
    localparam int GAP_SHORT_CYC = (GAP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_LONG_CYC  = (GAP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W         = 12;
    localparam int SHORT_BLOCK_BYTES = 256;

    // Relative address values.
    localparam logic [15:0] ADDR_DEFAULT  = 16'h0001;
    localparam logic [15:0] ADDR_BCAST    = 16'h0000;

    // Record lengths in bits and the CRC polynomial.
    localparam int REC_LEN    = 128;
    localparam int COND_LEN   = 32;
    localparam int CRC_W      = 7;
    localparam int BODY_LO    = 8;
    localparam logic [6:0] CRC_POLY = 7'h09;

    // Operating-conditions layout.
    localparam int COND_DONE_BIT = 31;
    localparam logic [23:0] COND_VOLT_WINDOW = 24'hff8000;

    // Fixed card-specific-data fields.
    localparam logic [1:0]  CSD_VERSION     = 2'h1;
    localparam logic [3:0]  SPEC_VERSION    = 4'h2;
    localparam logic [1:0]  RSVD2           = 2'h0;
    localparam logic [7:0]  ASYNC_ACCESS    = 8'h0e;
    localparam logic [7:0]  CLOCKED_ACCESS  = 8'h01;
    localparam logic [7:0]  XFER_RATE       = 8'h2a;
    localparam logic [11:0] CMD_CLASSES     = 12'h0ff;
    localparam logic [3:0]  READ_BLK_EXP    = 4'h9;
    localparam logic [3:0]  MISC_FLAGS      = 4'h8;
    localparam logic [11:0] DEV_SIZE        = 12'h7a7;
    localparam logic [2:0]  RD_CUR_LOW      = 3'h5;
    localparam logic [2:0]  RD_CUR_HIGH     = 3'h4;
    localparam logic [2:0]  WR_CUR_LOW      = 3'h5;
    localparam logic [2:0]  WR_CUR_HIGH     = 3'h4;
    localparam logic [2:0]  SIZE_MULT       = 3'h3;
    localparam logic [4:0]  SECTOR_SPAN     = 5'h00;
    localparam logic [4:0]  ERASE_SPAN      = 5'h0f;
    localparam logic [4:0]  PROTECT_SPAN    = 5'h01;
    localparam logic [0:0]  GRP_PROT_EN     = 1'h1;
    localparam logic [1:0]  DEFAULT_ECC     = 2'h0;
    localparam logic [2:0]  WR_SPEED        = 3'h2;
    localparam logic [3:0]  WRITE_BLK_EXP   = 4'h9;
    localparam logic [0:0]  PARTIAL_WR      = 1'h0;
    localparam logic [4:0]  RSVD5           = 5'h00;

    // User byte (record bits 15..8) positions.
    localparam int UB_FMT_GRP  = 7;
    localparam int UB_COPY     = 6;
    localparam int UB_PERM     = 5;
    localparam int UB_TEMP     = 4;
    localparam logic [7:0] UB_OTP_MASK   = 8'h60;
    localparam logic [7:0] UB_ERASE_MASK = 8'h13;

    // Records that can be read out.
    typedef enum logic [1:0] {
        REC_COND,
        REC_IDENT,
        REC_CARD
    } cir_rec_type;

    typedef enum logic {
        RD_IDLE,
        RD_SHIFT
    } cir_rd_state_type;

endpackage : cir_pkg

// ==== hdl/cir_crc7.sv ====
// Combinational 7-bit CRC over a 120-bit record body, msb first.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/1ps
`default_nettype none
module cir_crc7 (
    input  wire logic [119:0] body_i,
    output logic      [6:0]   crc_o
);
    logic [6:0] chain [0:120];

    assign chain[0] = '0;

    // One division step per body bit, from bit 119 down to bit 0.
    for (genvar g = 0; g < 120; g++) begin : g_step
        logic fb;
        assign fb = body_i[119 - g] ^ chain[g][6];
        assign chain[g + 1] = {chain[g][5:0], 1'b0} ^ (fb ? cir_pkg::CRC_POLY : 7'h00);
    end

    assign crc_o = chain[120];
endmodule : cir_crc7
`default_nettype wire

// ==== hdl/cir_regs.sv ====
// Card information register bank: operating conditions, identity record,
// relative address and card-specific-data record, with serial readout.
// Assumes the command decoder on the same clock drives the request ports
// and that flash storage keeps the user byte across power cycles.
`timescale 1ns/1ps
`default_nettype none
module cir_regs #(
    // Identity contents; all defaults are arbitrary.
    parameter logic [7:0]  MAKER_CODE   = 8'h5a,
    parameter logic [15:0] OEM_APP_CODE = 16'h1234,
    parameter logic [47:0] PRODUCT_NAME = 48'h414243444546,
    parameter logic [7:0]  PRODUCT_REV  = 8'h10,
    parameter logic [31:0] SERIAL_NUM   = 32'h00000001,
    parameter logic [7:0]  MFG_DATE     = 8'h01
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        spi_mode_i,
    input  wire logic        init_done_i,
    input  wire logic        addr_wr_i,
    input  wire logic [15:0] addr_data_i,
    input  wire logic [15:0] cmd_addr_i,
    output logic             addr_match_o,
    output logic             deselect_all_o,
    input  wire logic        ident_wr_i,
    output logic             ident_wr_refused_o,
    input  wire logic [7:0]  nv_user_i,
    input  wire logic        user_wr_i,
    input  wire logic [7:0]  user_data_i,
    input  wire logic        user_erase_i,
    output logic [7:0]       nv_user_o,
    input  wire logic        rd_start_i,
    input  wire cir_pkg::cir_rec_type rd_sel_i,
    input  wire logic        rd_ready_i,
    output logic             rd_valid_o,
    output logic             rd_bit_o,
    output logic             rd_last_o,
    input  wire logic        blk_done_i,
    input  wire logic [11:0] blk_len_i,
    output logic             next_blk_ok_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic                      rst_meta_ff;
    logic                      rst_sync_ff;
    logic                      rst_n;
    logic [15:0]               addr_ff;
    logic                      ident_ref_ff;
    logic [7:0]                user_ff;
    logic                      user_loaded_ff;
    logic                      done_ff;
    logic [31:0]               cond_rec;
    logic [127:0]              ident_rec;
    logic [127:0]              card_rec;
    logic [6:0]                ident_crc;
    logic [6:0]                card_crc;
    cir_pkg::cir_rd_state_type rd_state_ff;
    logic [127:0]              shift_ff;
    logic [6:0]                cnt_ff;
    logic [cir_pkg::GAP_W-1:0] gap_ff;

    // Reset release is synchronised; assertion stays asynchronous.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Relative address. It lives only in volatile flops, so a power cycle
    // returns it to the default and the host must assign it again.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= cir_pkg::ADDR_DEFAULT;
        end else if (addr_wr_i && !spi_mode_i && addr_data_i != cir_pkg::ADDR_BCAST) begin
            addr_ff <= addr_data_i;
        end
    end

    // Address decode for the command decoder; the value itself has no
    // read path out of the block.
    assign addr_match_o   = !spi_mode_i && (cmd_addr_i == addr_ff);
    assign deselect_all_o = !spi_mode_i && (cmd_addr_i == cir_pkg::ADDR_BCAST);

    ////////////////////////////////////////////////////////////////////////////
    // Any write aimed at the identity record is answered with a refusal.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ident_ref_ff <= 1'b0;
        end else begin
            ident_ref_ff <= ident_wr_i;
        end
    end
    assign ident_wr_refused_o = ident_ref_ff;

    ////////////////////////////////////////////////////////////////////////////
    // User byte: restored from flash after reset, then programmed or erased.
    // Copy and permanent protect are one-time bits, so a write can set them
    // but nothing clears them.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            user_ff        <= 8'h00;
            user_loaded_ff <= 1'b0;
        end else if (!user_loaded_ff) begin
            user_ff        <= nv_user_i;
            user_loaded_ff <= 1'b1;
        end else if (user_wr_i) begin
            user_ff <= user_data_i | (user_ff & cir_pkg::UB_OTP_MASK);
        end else if (user_erase_i) begin
            user_ff <= user_ff & ~cir_pkg::UB_ERASE_MASK;
        end
    end
    assign nv_user_o = user_ff;

    // Power-up status bit follows the internal initialisation.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= init_done_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Record assembly. Everything outside the user byte, its CRC and the power-up status bit is constant.
    assign cond_rec = {done_ff, 7'h00, cir_pkg::COND_VOLT_WINDOW};
    assign ident_rec = {MAKER_CODE, OEM_APP_CODE, PRODUCT_NAME, PRODUCT_REV,
                        SERIAL_NUM, MFG_DATE, ident_crc, 1'b1};
    assign card_rec = {cir_pkg::CSD_VERSION, cir_pkg::SPEC_VERSION,
                       cir_pkg::RSVD2,
                       cir_pkg::ASYNC_ACCESS, cir_pkg::CLOCKED_ACCESS,
                       cir_pkg::XFER_RATE, cir_pkg::CMD_CLASSES,
                       cir_pkg::READ_BLK_EXP, cir_pkg::MISC_FLAGS,
                       cir_pkg::RSVD2, cir_pkg::DEV_SIZE,
                       cir_pkg::RD_CUR_LOW, cir_pkg::RD_CUR_HIGH,
                       cir_pkg::WR_CUR_LOW, cir_pkg::WR_CUR_HIGH,
                       cir_pkg::SIZE_MULT,
                       cir_pkg::SECTOR_SPAN, cir_pkg::ERASE_SPAN,
                       cir_pkg::PROTECT_SPAN, cir_pkg::GRP_PROT_EN,
                       cir_pkg::DEFAULT_ECC, cir_pkg::WR_SPEED,
                       cir_pkg::WRITE_BLK_EXP, cir_pkg::PARTIAL_WR,
                       cir_pkg::RSVD5, user_ff, card_crc, 1'b1};

    // Both CRCs are recomputed continuously, so a user-byte change is
    // covered without any explicit update step.
    cir_crc7 u_ident_crc (
        .body_i (ident_rec[127:8]),
        .crc_o  (ident_crc)
    );
    cir_crc7 u_card_crc (
        .body_i (card_rec[127:8]),
        .crc_o  (card_crc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serial readout, one bit per accepted handshake, msb first. The record
    // is snapshotted at start so a user write mid-transfer cannot tear it.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_ff <= cir_pkg::RD_IDLE;
            shift_ff    <= '0;
            cnt_ff      <= 7'h00;
        end else begin
            unique case (rd_state_ff)
                cir_pkg::RD_IDLE: begin
                    if (rd_start_i) begin
                        rd_state_ff <= cir_pkg::RD_SHIFT;
                        unique case (rd_sel_i)
                            cir_pkg::REC_COND: begin
                                shift_ff <= {cond_rec, 96'h0};
                                cnt_ff   <= 7'(cir_pkg::COND_LEN - 1);
                            end
                            cir_pkg::REC_IDENT: begin
                                shift_ff <= ident_rec;
                                cnt_ff   <= 7'(cir_pkg::REC_LEN - 1);
                            end
                            default: begin
                                shift_ff <= card_rec;
                                cnt_ff   <= 7'(cir_pkg::REC_LEN - 1);
                            end
                        endcase
                    end
                end
                cir_pkg::RD_SHIFT: begin
                    if (rd_ready_i) begin
                        shift_ff <= {shift_ff[126:0], 1'b0};
                        cnt_ff   <= cnt_ff - 7'h01;
                        if (cnt_ff == 7'h00) begin
                            rd_state_ff <= cir_pkg::RD_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign rd_valid_o = (rd_state_ff == cir_pkg::RD_SHIFT);
    assign rd_bit_o   = shift_ff[127];
    assign rd_last_o  = rd_valid_o && (cnt_ff == 7'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Block-to-block gap. Short blocks need the long settle time.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff <= '0;
        end else if (blk_done_i) begin
            if (blk_len_i < 12'(cir_pkg::SHORT_BLOCK_BYTES)) begin
                gap_ff <= cir_pkg::GAP_W'(cir_pkg::GAP_LONG_CYC);
            end else begin
                gap_ff <= cir_pkg::GAP_W'(cir_pkg::GAP_SHORT_CYC);
            end
        end else if (gap_ff != '0) begin
            gap_ff <= gap_ff - 1'b1;
        end
    end
    assign next_blk_ok_o = (gap_ff == '0);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_rd_begin;
        rd_state_ff == cir_pkg::RD_IDLE && rd_start_i;
    endsequence
    sequence s_shift_step;
        rd_valid_o && rd_ready_i && !rd_last_o;
    endsequence

    chk_zero_addr_kept: assert property (
        addr_wr_i && addr_data_i == cir_pkg::ADDR_BCAST |=> $stable(addr_ff))
        else $error("Zero address was assigned.");
    chk_spi_addr_blocked: assert property (
        spi_mode_i && addr_wr_i |=> $stable(addr_ff) && (!spi_mode_i || !addr_match_o))
        else $error("Address changed or matched in SPI mode.");
    chk_addr_takes: assert property (
        addr_wr_i && !spi_mode_i && addr_data_i != 16'h0000
        |=> addr_ff == $past(addr_data_i))
        else $error("Assigned address not taken.");
    chk_ident_refused: assert property (
        ident_wr_i |=> ident_wr_refused_o && $stable(ident_rec))
        else $error("Identity write not refused.");
    chk_ident_crc_ok: assert property (
        ident_rec[0] && ident_rec[7:1] == ident_crc)
        else $error("Identity tail wrong.");
    chk_card_fixed: assert property (
        card_rec[127:16] == {2'h1, 4'h2, 2'h0, 8'h0e, 8'h01, 8'h2a, 12'h0ff,
            4'h9, 4'h8, 2'h0, 12'h7a7, 12'hb2c, 3'h3, 5'h00, 5'h0f, 5'h01,
            1'h1, 2'h0, 3'h2, 4'h9, 1'h0, 5'h00} && card_rec[0])
        else $error("Fixed card data field wrong.");
    chk_otp_sticky: assert property (
        user_loaded_ff && user_ff[cir_pkg::UB_PERM] |=> user_ff[cir_pkg::UB_PERM])
        else $error("Permanent protect cleared.");
    chk_msb_first: assert property (
        s_rd_begin ##1 rd_valid_o |-> rd_bit_o == $past(rd_sel_i == cir_pkg::REC_COND
            ? cond_rec[31] : (rd_sel_i == cir_pkg::REC_IDENT ? ident_rec[127]
            : card_rec[127])))
        else $error("Readout did not start at msb.");
    chk_shift_order: assert property (
        s_shift_step ##1 rd_valid_o |-> rd_bit_o == $past(shift_ff[126]))
        else $error("Readout bit order wrong.");
    chk_short_gap: assert property (
        blk_done_i && blk_len_i < 12'(cir_pkg::SHORT_BLOCK_BYTES) |=> !next_blk_ok_o [*8]
        ##1 gap_ff == cir_pkg::GAP_W'(cir_pkg::GAP_LONG_CYC - 8))
        else $error("Short block gap wrong.");
    chk_long_gap: assert property (
        blk_done_i && blk_len_i >= 12'(cir_pkg::SHORT_BLOCK_BYTES) |=> !next_blk_ok_o [*8]
        ##42 !next_blk_ok_o ##1 next_blk_ok_o)
        else $error("Block gap not one microsecond.");
endmodule : cir_regs
`default_nettype wire

// ==== test/cir_host_model.sv ====
// Host-side partner: accepts record bits from the readout port.
// Assumes the readout handshake runs on the shared core clock.
`timescale 1ns/1ps
`default_nettype none
module cir_host_model (
    input  wire logic    clk_i,
    input  wire logic    rst_n_i,
    input  wire logic    slow_i,
    input  wire logic    start_i,
    input  wire logic    valid_i,
    input  wire logic    bit_i,
    input  wire logic    last_i,
    output logic         ready_o,
    output logic [127:0] rec_o,
    output logic [7:0]   cnt_o,
    output logic         done_o
);
    logic tog_ff;
    // A slow host accepts only every other cycle, so the card must hold its bit.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_ff <= 1'b0;
        end else begin
            tog_ff <= ~tog_ff;
        end
    end
    assign ready_o = slow_i ? tog_ff : 1'b1;
    ////////////////////////////////////////////////////////////
    // Bits arrive msb first, so each accepted bit shifts in at the bottom.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rec_o  <= '0;
            cnt_o  <= '0;
            done_o <= 1'b0;
        end else if (start_i) begin
            rec_o  <= '0;
            cnt_o  <= '0;
            done_o <= 1'b0;
        end else if (valid_i && ready_o) begin
            rec_o  <= {rec_o[126:0], bit_i};
            cnt_o  <= cnt_o + 8'h01;
            done_o <= last_i;
        end
    end
endmodule : cir_host_model
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the card information register bank.
// Assumes the host model in cir_host_model.sv and the shared package.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [119:0] ID_BODY = {8'h3c, 16'h0bad, 48'h6e616d650a0b, 8'h21,
                                        32'hcafe0042, 8'h7e}; // Arbitrary values.
    logic        clk_i, rst_n, spi_mode, init_done, addr_wr, ident_wr, user_wr;
    logic        user_erase, rd_start, blk_done, slow, addr_match, deselect_all;
    logic        wr_refused, rd_ready, rd_valid, rd_bit, rd_last, next_ok, done;
    logic [15:0] addr_data, cmd_addr;
    logic [7:0]  nv_user_in, user_data, nv_user_out, cnt;
    logic [11:0] blk_len;
    logic [127:0] rec;
    cir_pkg::cir_rec_type rd_sel;
    int          n_errors, num_checks;

    cir_regs #(.MAKER_CODE(ID_BODY[119:112]), .OEM_APP_CODE(ID_BODY[111:96]),
        .PRODUCT_NAME(ID_BODY[95:48]), .PRODUCT_REV(ID_BODY[47:40]),
        .SERIAL_NUM(ID_BODY[39:8]), .MFG_DATE(ID_BODY[7:0])) uut (
        .clk_i(clk_i), .rst_n_i(rst_n), .spi_mode_i(spi_mode), .init_done_i(init_done),
        .addr_wr_i(addr_wr), .addr_data_i(addr_data), .cmd_addr_i(cmd_addr),
        .addr_match_o(addr_match), .deselect_all_o(deselect_all), .ident_wr_i(ident_wr),
        .ident_wr_refused_o(wr_refused), .nv_user_i(nv_user_in), .user_wr_i(user_wr),
        .user_data_i(user_data), .user_erase_i(user_erase), .nv_user_o(nv_user_out),
        .rd_start_i(rd_start), .rd_sel_i(rd_sel), .rd_ready_i(rd_ready),
        .rd_valid_o(rd_valid), .rd_bit_o(rd_bit), .rd_last_o(rd_last),
        .blk_done_i(blk_done), .blk_len_i(blk_len), .next_blk_ok_o(next_ok));
    cir_host_model host (.clk_i(clk_i), .rst_n_i(rst_n), .slow_i(slow),
        .start_i(rd_start), .valid_i(rd_valid), .bit_i(rd_bit), .last_i(rd_last),
        .ready_o(rd_ready), .rec_o(rec), .cnt_o(cnt), .done_o(done));

    // Free-running 50 MHz core clock.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////
    // Reference CRC, bit-serial so it shares nothing with the design's form.
    function automatic logic [6:0] crc7(input logic [119:0] b);
        logic [6:0] c;
        c = '0;
        for (int i = 119; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((c[6] ^ b[i]) ? 7'h09 : 7'h00);
        end
        return c;
    endfunction : crc7

    function automatic logic [127:0] card_exp(input logic [7:0] ub);
        logic [119:0] b;
        b = {2'h1, 4'h2, 2'h0, 8'h0e, 8'h01, 8'h2a, 12'h0ff, 4'h9, 4'h8, 2'h0, 12'h7a7,
             3'h5, 3'h4, 3'h5, 3'h4, 3'h3, 5'h00, 5'h0f, 5'h01, 1'h1, 2'h0, 3'h2,
             4'h9, 1'h0, 5'h00, ub};
        return {b, crc7(b), 1'b1};
    endfunction : card_exp

    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////
    // Bus-cycle tasks; every input changes on or just after the falling edge.
    task automatic do_reset(input logic [7:0] nv);
        nv_user_in = nv;
        rst_n = 1'b0;
        repeat (20) @(negedge clk_i);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask : do_reset

    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask : pulse

    task automatic probe(input logic [15:0] a, input logic m, input logic d);
        cmd_addr = a;
        #1;
        check("address match", 128'(addr_match), 128'(m));
        check("deselect all", 128'(deselect_all), 128'(d));
    endtask : probe

    task automatic read_rec(input cir_pkg::cir_rec_type sel, input logic s,
                            input logic [127:0] exp, input logic [7:0] n);
        int i;
        rd_sel = sel;
        slow = s;
        pulse(rd_start);
        i = 0;
        while (done !== 1'b1 && i < 600) begin
            @(negedge clk_i);
            i++;
        end
        check("record", rec, exp);
        check("bit count", 128'(cnt), 128'(n));
    endtask : read_rec

    task automatic gap(input logic [11:0] len, input int exp);
        int n;
        blk_len = len;
        pulse(blk_done);
        n = 0;
        while (next_ok !== 1'b1 && n < 4000) begin
            n++;
            @(negedge clk_i);
        end
        check("gap cycles", 128'(n), 128'(exp));
    endtask : gap

    task automatic user_op(input logic [7:0] v, input logic wr, input logic er);
        @(negedge clk_i);
        user_data = v;
        user_wr = wr;
        user_erase = er;
        @(negedge clk_i);
        user_wr = 1'b0;
        user_erase = 1'b0;
        @(negedge clk_i);
    endtask : user_op
    ////////////////////////////////////////////////////////////
    // The watchdog allows about seven times the expected run length.
    initial begin
        #(30000 * 20);
        n_errors++;
        finish_test();
    end

    // Main sequence of scenarios.
    initial begin
        {spi_mode, init_done, addr_wr, ident_wr, user_wr, user_erase} = '0;
        {rd_start, blk_done, slow, addr_data, cmd_addr, user_data} = '0;
        {blk_len, n_errors, num_checks} = '0;
        rd_sel = cir_pkg::REC_COND;
        do_reset(8'ha5);
        probe(16'h0001, 1'b1, 1'b0);
        probe(16'h0000, 1'b0, 1'b1);
        addr_data = 16'h1234;
        pulse(addr_wr);
        probe(16'h1234, 1'b1, 1'b0);
        probe(16'h0001, 1'b0, 1'b0);
        addr_data = 16'h0000;
        pulse(addr_wr);
        probe(16'h1234, 1'b1, 1'b0);
        spi_mode = 1'b1;
        probe(16'h1234, 1'b0, 1'b0);
        probe(16'h0000, 1'b0, 1'b0);
        addr_data = 16'h0777;
        pulse(addr_wr);
        read_rec(cir_pkg::REC_IDENT, 1'b0, {ID_BODY, crc7(ID_BODY), 1'b1}, 8'd128);
        spi_mode = 1'b0;
        probe(16'h1234, 1'b1, 1'b0);
        read_rec(cir_pkg::REC_COND, 1'b0, {96'h0, 8'h00, 24'hff8000}, 8'd32);
        init_done = 1'b1;
        read_rec(cir_pkg::REC_COND, 1'b1, {96'h0, 8'h80, 24'hff8000}, 8'd32);
        read_rec(cir_pkg::REC_IDENT, 1'b1, {ID_BODY, crc7(ID_BODY), 1'b1}, 8'd128);
        pulse(ident_wr);
        check("write refused", 128'(wr_refused), 128'(1));
        @(negedge clk_i);
        check("refusal width", 128'(wr_refused), 128'(0));
        read_rec(cir_pkg::REC_IDENT, 1'b0, {ID_BODY, crc7(ID_BODY), 1'b1}, 8'd128);
        read_rec(cir_pkg::REC_CARD, 1'b1, card_exp(8'ha5), 8'd128);
        check("user byte restore", 128'(nv_user_out), 128'(8'ha5));
        user_op(8'h00, 1'b1, 1'b0);
        check("user write keeps OTP", 128'(nv_user_out), 128'(8'h20));
        user_op(8'hff, 1'b1, 1'b1);
        check("write beats erase", 128'(nv_user_out), 128'(8'hff));
        user_op(8'h00, 1'b0, 1'b1);
        check("user erase", 128'(nv_user_out), 128'(8'hec));
        read_rec(cir_pkg::REC_CARD, 1'b0, card_exp(8'hec), 8'd128);
        gap(12'd512, 50);
        gap(12'd256, 50);
        gap(12'd255, 3100);
        do_reset(8'h5a);
        probe(16'h1234, 1'b0, 1'b0);
        probe(16'h0001, 1'b1, 1'b0);
        read_rec(cir_pkg::REC_CARD, 1'b0, card_exp(8'h5a), 8'd128);
        finish_test();
    end
endmodule : tb
`default_nettype wire
